//--- include/fsm_pkg.sv
package fsm_pkg;
  localparam logic [7:0] FSM_READ_STATUS_OP = 8'h05;
  localparam logic [7:0] FSM_READ_FACTORY_OP = 8'h44;
  localparam logic [7:0] FSM_FACTORY_OFF = 8'h00;
  localparam logic [7:0] FSM_FACTORY_ON = 8'hFF;
  localparam logic [7:0] FSM_STATUS_RESET = 8'h00;
  localparam int FSM_SPI_CMD_CLOCKS = 8;
  localparam int FSM_QUAD_CMD_CLOCKS = 2;
  localparam int FSM_OTP_BITS = 8192;
  localparam int FSM_CLK_MHZ = 20;
  localparam int FSM_SLEEP_ENTRY_NS = 10000;
  localparam int FSM_WAKE_PULSE_NS = 20;
  localparam int FSM_WAKE_RECOVERY_NS = 30000;
  localparam int FSM_SLEEP_ENTRY_CYC = (FSM_SLEEP_ENTRY_NS * FSM_CLK_MHZ) / 1000;
  localparam int FSM_WAKE_PULSE_RAW = (FSM_WAKE_PULSE_NS * FSM_CLK_MHZ + 999) / 1000;
  localparam int FSM_WAKE_PULSE_CYC = (FSM_WAKE_PULSE_RAW < 1) ? 1 : FSM_WAKE_PULSE_RAW;
  localparam int FSM_WAKE_RECOVERY_CYC = (FSM_WAKE_RECOVERY_NS * FSM_CLK_MHZ) / 1000;
  typedef enum logic [1:0] {
    FSM_PWR_STANDBY = 2'b00,
    FSM_PWR_ENTERING = 2'b01,
    FSM_PWR_SLEEP = 2'b10,
    FSM_PWR_WAKING = 2'b11
  } fsm_pwr_t;
endpackage

//--- include/fsm_frame_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fsm_frame_if;
  logic frame_start;
  logic frame_end;
  logic bit_tick;
  logic [7:0] opcode;
  logic opcode_valid;
  logic on_boundary;
  modport shifter (output frame_start, frame_end, bit_tick, opcode, opcode_valid, on_boundary);
  modport control (input frame_start, frame_end, bit_tick, opcode, opcode_valid, on_boundary);
endinterface
`default_nettype wire

//--- rtl/fsm_frame_shifter.sv
`timescale 1ns/100ps
`default_nettype none
// collects the opcode byte of each chip-select frame and tracks byte alignment
module fsm_frame_shifter (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // synchronised pins and command mode
  input wire logic cs_n_s,
  input wire logic sclk_rise,
  input wire logic [3:0] io_s,
  input wire logic quad_command_mode,
  // decoded frame
  fsm_frame_if.shifter frm
);
  import fsm_pkg::*;
  logic cs_n_d;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic got_op;
  wire in_frame = ~cs_n_s;
  wire [2:0] last_cnt = quad_command_mode ? 3'h1 : 3'h7;
  wire byte_done = sclk_rise && in_frame && (bit_cnt == last_cnt);
  // upper lines are not looked at in single-line mode
  wire [7:0] next_shreg = quad_command_mode ? {shreg[3:0], io_s} : {shreg[6:0], io_s[0]};
  assign frm.frame_start = cs_n_d & ~cs_n_s;
  assign frm.frame_end = ~cs_n_d & cs_n_s;
  assign frm.bit_tick = sclk_rise & in_frame;
  assign frm.opcode = shreg;
  assign frm.opcode_valid = got_op;
  assign frm.on_boundary = (bit_cnt == 3'h0);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_n_d <= 1'b1;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      got_op <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      if (frm.frame_start) begin
        bit_cnt <= 3'h0;
        got_op <= 1'b0;
      end else if (frm.bit_tick) begin
        bit_cnt <= byte_done ? 3'h0 : bit_cnt + 3'h1;
        if (!got_op) begin
          shreg <= next_shreg;
        end
        if (byte_done) begin
          got_op <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/fsm_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: fast erase only after armed factory mode
// R2: host sends unlock, arm, then page write
// R3: arm opcode alone in one frame; code also takes it when whole extra bytes follow in the frame
// R4: suspend refused while factory mode active
// R5: factory mode cleared by resets, op completion
// R6: factory status shifted out like status read
// R7: factory status read only when idle
// R8: status byte 00 idle, FF armed
// R9: arm sets all ones, completion clears
// R10: sleep opcode needs byte-aligned frame end
// R11: opcodes in 8 or 2 clocks
// R12: enter deep sleep after entry delay
// R13: deep sleep ignores all instructions
// R14: host waits minimum dwell before waking
// R15: wake on pulse, recover then standby
// R16: secure area maps reads/writes to OTP
// R17: locked OTP allows only reads
// R18: leave command returns to main array
// R19: special opcodes are parameters; the factory status read opcode is the fixed FSM_READ_FACTORY_OP
module fsm_mode_ctrl #(
  parameter logic [7:0] FACTORY_ARM_OP = 8'hA0, // R19
  parameter logic [7:0] DEEP_SLEEP_OP = 8'hA1,
  parameter logic [7:0] ENTER_SECURE_OP = 8'hA2,
  parameter logic [7:0] LEAVE_SECURE_OP = 8'hA3,
  parameter logic [7:0] SMALL_WIPE_OP = 8'hA4,
  parameter logic [7:0] HALF_BLOCK_WIPE_OP = 8'hA5,
  parameter logic [7:0] BLOCK_WIPE_OP = 8'hA6,
  parameter logic [7:0] CHIP_WIPE_OP = 8'hA7,
  parameter logic [7:0] PAGE_WRITE_OP = 8'hA8,
  parameter logic [7:0] SUSPEND_OP = 8'hA9,
  parameter int SLEEP_ENTRY_CYC = fsm_pkg::FSM_SLEEP_ENTRY_CYC,
  parameter int WAKE_RECOVERY_CYC = fsm_pkg::FSM_WAKE_RECOVERY_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic so_out,
  output logic so_oe,
  // mode and core handshake
  input wire logic quad_command_mode,
  input wire logic soft_reset_done,
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic otp_locked,
  // decisions to the array core
  output logic fast_erase,
  output logic fast_program,
  output logic suspend_allowed,
  output logic secure_area,
  output logic otp_write_blocked,
  output logic deep_sleep,
  output logic cmd_ignore,
  output logic [7:0] factory_mode_status
);
  import fsm_pkg::*;
  fsm_frame_if frm ();
  logic [1:0] cs_sync, sclk_sync;
  logic [3:0] io_sync0, io_sync1;
  logic sclk_d;
  fsm_pwr_t pwr_state;
  logic [31:0] pwr_cnt;
  logic [7:0] out_shift;
  logic out_active;
  logic armed;
  logic was_wipe;
  logic was_page;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_sync <= 2'b11;
      sclk_sync <= 2'b00;
      io_sync0 <= 4'h0;
      io_sync1 <= 4'h0;
      sclk_d <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[0], sclk};
      io_sync0 <= io_in;
      io_sync1 <= io_sync0;
      sclk_d <= sclk_sync[1];
    end
  end
  wire cs_n_s = cs_sync[1];
  wire sclk_rise = sclk_sync[1] & ~sclk_d;
  wire sclk_fall = ~sclk_sync[1] & sclk_d;
  fsm_frame_shifter u_shift (
    .mclk(mclk),
    .rst(rst),
    .cs_n_s(cs_n_s),
    .sclk_rise(sclk_rise),
    .io_s(io_sync1),
    .quad_command_mode(quad_command_mode),
    .frm(frm.shifter)
  );
  // a command other than the factory status read counts only if the frame ends on a byte boundary after its opcode byte
  wire op_frame = frm.frame_end && frm.opcode_valid && frm.on_boundary; // R10 R11
  wire awake = (pwr_state == FSM_PWR_STANDBY);
  assign cmd_ignore = !awake; // R13
  wire do_arm = op_frame && awake && frm.opcode == FACTORY_ARM_OP; // R3
  wire do_sleep = op_frame && awake && frm.opcode == DEEP_SLEEP_OP; // R10
  wire do_enter = op_frame && awake && frm.opcode == ENTER_SECURE_OP;
  wire do_leave = op_frame && awake && frm.opcode == LEAVE_SECURE_OP;
  wire is_wipe = (frm.opcode == SMALL_WIPE_OP) || (frm.opcode == HALF_BLOCK_WIPE_OP) ||
      (frm.opcode == BLOCK_WIPE_OP) || (frm.opcode == CHIP_WIPE_OP);
  wire is_page = frm.opcode == PAGE_WRITE_OP;
  // read opcode: first byte seen while frame still open
  wire read_req = frm.opcode_valid && !out_active && !frm.frame_end && awake &&
      frm.opcode == FSM_READ_FACTORY_OP && frm.on_boundary;
  logic read_taken;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
      was_wipe <= 1'b0;
      was_page <= 1'b0;
    end else begin
      // a fresh arm landing with a completion keeps the new arm: set wins
      if (do_arm) begin
        armed <= 1'b1; // R9
      end else if (soft_reset_done || (op_done && (was_wipe || was_page))) begin
        armed <= 1'b0; // R5 R9
      end
      if (soft_reset_done || (op_done && (was_wipe || was_page))) begin
        was_wipe <= 1'b0;
        was_page <= 1'b0;
      end else if (armed && op_frame && awake && !op_busy) begin
        was_wipe <= is_wipe; // R1
        was_page <= is_page; // R2
      end
    end
  end
  assign factory_mode_status = armed ? FSM_FACTORY_ON : FSM_FACTORY_OFF; // R8
  assign fast_erase = armed && was_wipe; // R1
  assign fast_program = armed && was_page;
  assign suspend_allowed = !armed; // R4
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      secure_area <= 1'b0;
    end else if (do_enter) begin
      secure_area <= 1'b1; // R16
    end else if (do_leave) begin
      secure_area <= 1'b0; // R18
    end
  end
  assign otp_write_blocked = secure_area && otp_locked; // R17
  // deep sleep sequencing; entry/recovery counts measured in mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_state <= FSM_PWR_STANDBY;
      pwr_cnt <= 32'h0;
    end else begin
      unique case (pwr_state)
        FSM_PWR_STANDBY: begin
          pwr_cnt <= 32'h0;
          if (do_sleep) begin
            pwr_state <= FSM_PWR_ENTERING;
          end
        end
        FSM_PWR_ENTERING: begin
          pwr_cnt <= pwr_cnt + 32'h1;
          if (pwr_cnt >= 32'(SLEEP_ENTRY_CYC)) begin
            pwr_state <= FSM_PWR_SLEEP; // R12
            pwr_cnt <= 32'h0;
          end
        end
        FSM_PWR_SLEEP: begin
          // R14 minimum dwell is the host's duty; low time is counted
          if (!cs_n_s) begin
            pwr_cnt <= pwr_cnt + 32'h1;
          end else if (pwr_cnt >= 32'(FSM_WAKE_PULSE_CYC)) begin
            pwr_state <= FSM_PWR_WAKING; // R15
            pwr_cnt <= 32'h0;
          end else begin
            pwr_cnt <= 32'h0;
          end
        end
        FSM_PWR_WAKING: begin
          pwr_cnt <= pwr_cnt + 32'h1;
          if (pwr_cnt >= 32'(WAKE_RECOVERY_CYC)) begin
            pwr_state <= FSM_PWR_STANDBY; // R15
          end
        end
      endcase
    end
  end
  assign deep_sleep = (pwr_state == FSM_PWR_SLEEP);
  // status byte out msb first on falling clock edges, same as plain status read
  assign read_taken = read_req && !op_busy; // R7
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_active <= 1'b0;
      out_shift <= FSM_STATUS_RESET;
      so_out <= 1'b0;
    end else if (cs_n_s) begin
      out_active <= 1'b0;
    end else if (read_taken && !out_active) begin
      out_active <= 1'b1; // R6
      out_shift <= factory_mode_status;
    end else if (out_active && sclk_fall) begin
      // rotating lets the host read the byte repeatedly, like the plain status read
      so_out <= out_shift[7];
      out_shift <= {out_shift[6:0], out_shift[7]};
    end
  end
  assign so_oe = out_active && !cs_n_s;
endmodule
`default_nettype wire

//--- verif/fsm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: every sclk phase spans 4 mclk so the synchroniser sees each edge
module fsm_host_model (
  // clock and mode
  input wire logic mclk,
  input wire logic quad,
  // serial pins
  input wire logic so_out,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io = 4'h5;
  end
  task automatic ph();
    repeat (4) @(negedge mclk);
  endtask
  // clocks past the opcode shift the reply in; lines left idle keep toggling
  task automatic xfer(input logic [7:0] op, input int extra, output logic [7:0] rd);
    int n;
    n = quad ? 2 : 8;
    rd = 8'h00;
    cs_n = 1'b0;
    ph();
    for (int i = 0; i < n + extra; i++) begin
      if (i >= n) io = ~io;
      else if (quad) io = (i == 0) ? op[7:4] : op[3:0];
      else io = {~io[3:1], op[7 - i]};
      ph();
      rd = {rd[6:0], so_out};
      sclk = 1'b1;
      ph();
      sclk = 1'b0;
    end
    ph();
    cs_n = 1'b1;
    io = ~io;
    ph();
    ph();
  endtask
endmodule
`default_nettype wire

//--- verif/fsm_mode_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fsm_mode_ctrl_monitor #(
  parameter int SLEEP_ENTRY_CYC = 4,
  parameter int WAKE_RECOVERY_CYC = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // core handshake
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic soft_reset_done,
  // watched outputs
  input wire logic so_oe,
  input wire logic fast_erase,
  input wire logic fast_program,
  input wire logic suspend_allowed,
  input wire logic deep_sleep,
  input wire logic cmd_ignore,
  input wire logic [7:0] factory_mode_status
);
  localparam int SL_HI = SLEEP_ENTRY_CYC + 3;
  // wake time starts once the low pulse has ended, when deep_sleep falls
  localparam int WK_HI = WAKE_RECOVERY_CYC + 36;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_enter;
    !deep_sleep[*2] ##[1:SL_HI] deep_sleep;
  endsequence
  sequence s_wake;
    cmd_ignore[*3] ##[0:WK_HI] !cmd_ignore;
  endsequence
  a_status_code: assert property (
    factory_mode_status == 8'h00 || factory_mode_status == 8'hFF) else $error("bad status code");
  a_suspend_gate: assert property (
    suspend_allowed == (factory_mode_status == 8'h00)) else $error("suspend while armed");
  a_done_clears: assert property (
    (fast_erase || fast_program) && op_done |-> ##[1:2] factory_mode_status == 8'h00)
    else $error("armed after op end");
  a_soft_clears: assert property (
    soft_reset_done |-> ##[1:2] factory_mode_status == 8'h00) else $error("armed after soft reset");
  a_sleep_entry: assert property ($rose(cmd_ignore) |-> s_enter)
    else $error("sleep entry timing");
  a_wake_recover: assert property ($fell(deep_sleep) |-> s_wake)
    else $error("no standby after wake");
  a_sleep_quiet: assert property (deep_sleep |-> cmd_ignore) else $error("sleep not ignoring");
  a_read_idle: assert property ($rose(so_oe) |-> !op_busy && !cmd_ignore)
    else $error("status read while busy");
endmodule
bind fsm_mode_ctrl fsm_mode_ctrl_monitor #(.SLEEP_ENTRY_CYC(SLEEP_ENTRY_CYC),
  .WAKE_RECOVERY_CYC(WAKE_RECOVERY_CYC)) fsm_mode_ctrl_monitor_inst (.mclk, .rst, .op_busy,
  .op_done, .soft_reset_done, .so_oe, .fast_erase, .fast_program, .suspend_allowed, .deep_sleep,
  .cmd_ignore, .factory_mode_status);
`default_nettype wire

//--- verif/tb_flash_special_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_flash_special_mode_control;
  import fsm_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic quad = 1'b0;
  logic srd = 1'b0;
  logic busy = 1'b0;
  logic done = 1'b0;
  logic lock = 1'b0;
  logic oe_seen = 1'b0;
  logic cs_n, sclk, so_out, so_oe, fe, fp, sus, sec, owb, dsl, ign;
  logic [3:0] io;
  logic [7:0] st, r;
  logic [7:0] ops [5] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8};
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (so_oe) oe_seen <= 1'b1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  fsm_mode_ctrl #(.SLEEP_ENTRY_CYC(4), .WAKE_RECOVERY_CYC(4)) fsm_mode_ctrl_inst (.mclk(mclk),
    .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io), .so_out(so_out), .so_oe(so_oe),
    .quad_command_mode(quad), .soft_reset_done(srd), .op_busy(busy), .op_done(done),
    .otp_locked(lock), .fast_erase(fe), .fast_program(fp), .suspend_allowed(sus),
    .secure_area(sec), .otp_write_blocked(owb), .deep_sleep(dsl), .cmd_ignore(ign),
    .factory_mode_status(st));
  fsm_host_model fsm_host_model_inst (.mclk(mclk), .quad(quad), .so_out(so_out), .cs_n(cs_n),
    .sclk(sclk), .io(io));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [7:0] c, input int x = 0);
    fsm_host_model_inst.xfer(c, x, r);
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    busy = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("status", FSM_STATUS_RESET, st);
    op(8'hA6);
    chk("unarmed", 8'h00, {7'h00, fe});
    for (int k = 0; k < 5; k++) begin
      quad = k[0];
      op(8'hB0);
      op(8'hA0);
      chk("armed", FSM_FACTORY_ON, st);
      chk("suspend", 8'h00, {7'h00, sus});
      if (k == 0) op(FSM_READ_FACTORY_OP, 8);
      if (k == 0) chk("read", FSM_FACTORY_ON, r);
      op(ops[k]);
      busy = 1'b1;
      chk("fast", 8'h01, {7'h00, (k < 4) ? fe : fp});
      oe_seen = 1'b0;
      if (k == 2) op(FSM_READ_FACTORY_OP, 8);
      chk("busy_read", 8'h00, {7'h00, oe_seen});
      strobe(done);
      chk("cleared", FSM_FACTORY_OFF, st);
    end
    op(8'hA0);
    strobe(srd);
    chk("soft", FSM_FACTORY_OFF, st);
    op(FSM_READ_FACTORY_OP, 8);
    chk("read_off", FSM_FACTORY_OFF, r);
    quad = 1'b1;
    op(8'hA2);
    lock = 1'b1;
    @(negedge mclk);
    chk("secure", 8'h01, {7'h00, sec});
    chk("otp_block", 8'h01, {7'h00, owb});
    quad = 1'b0;
    op(8'hA3);
    lock = 1'b0;
    chk("leave", 8'h00, {7'h00, sec});
    op(8'hA1, 3);
    repeat (12) @(negedge mclk);
    chk("dp_odd", 8'h00, {7'h00, dsl});
    quad = 1'b1;
    op(8'hA1);
    repeat (12) @(negedge mclk);
    chk("dp", 8'h01, {7'h00, dsl});
    repeat (20) @(negedge mclk);
    op(8'hA2);
    repeat (12) @(negedge mclk);
    chk("woken", 8'h00, {6'h00, dsl, ign});
    chk("ignored", 8'h00, {7'h00, sec});
    summarize();
  end
endmodule
`default_nettype wire
